// File: design/dsc_ctrl.sv
// Purpose: command issuer that keeps the memory's command spacing minimums
// Assumes: one clock domain; mode inputs stable while commands are pending
// Notes: gaps are counted between issue cycles on the dram_* outputs
//
// Contract
// - read after write, same bank group: max(4 cycles, 7.5 ns) after the write burst ends (write latency plus 4 cycles)
// - read to precharge same bank: at least max(4 cycles, 7.5 ns)
// - write recovery 15 ns; crc with mask adds max(5 cycles, 3.75 ns)
// - crc with mask: other-group write-to-read gets max(5, 3.75 ns) extra
// - crc with mask: same-group write-to-read gets max(5, 3.75 ns) extra
// - two mode register sets at least eight cycles apart
// - other commands wait max(24 cycles, 15 ns) after mode register set
// - one recovery cycle after multi-purpose register read
// - after multi-purpose register write wait update delay plus AL plus PL
// - auto-precharge write keeps bank busy for WR plus rounded-up precharge
// - in latency mode, command and address follow chip select by four cycles
`timescale 1ns/100ps
`default_nettype none
module dsc_ctrl (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic req_valid,
	input wire dsc_pkg::dsc_cmd_t req_cmd,
	input wire logic [1:0] req_bg,
	input wire logic [1:0] req_ba,
	input wire logic req_ap,
	input wire logic crc_dm_en,
	input wire logic cal_en,
	input wire logic [5:0] cas_lat,
	input wire logic [5:0] cas_wr_lat,
	input wire logic [5:0] add_lat,
	input wire logic [5:0] par_lat,
	input wire logic [5:0] wr_prog,
	output logic req_ready,
	output logic dram_cs_n,
	output dsc_pkg::dsc_cmd_t dram_cmd,
	output logic [1:0] dram_bg,
	output logic [1:0] dram_ba,
	output logic dram_ap,
	output logic issued,
	output logic rd_strobe_win
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	dsc_pkg::dsc_state_t st_q, st_d;
	dsc_pkg::dsc_cmd_t cmd_q, cmd_d;
	logic [1:0] bg_q, bg_d, ba_q, ba_d;
	logic ap_q, ap_d;
	logic [2:0] cal_q, cal_d;
	logic ready_q, ready_d, cs_n_q, cs_n_d, issued_q, issued_d;
	dsc_pkg::dsc_cmd_t pin_cmd_q, pin_cmd_d;
	logic [1:0] pin_bg_q, pin_bg_d, pin_ba_q, pin_ba_d;
	logic pin_ap_q, pin_ap_d;
	logic [dsc_pkg::HIST_W-1:0] hist_q, hist_d;
	logic win_q, win_d;

	// ---------------------------------------------------------------
	// spacing timers
	// ---------------------------------------------------------------
	logic fire;
	logic [dsc_pkg::TW-1:0] bank_cnt [dsc_pkg::NBANK];
	logic [dsc_pkg::TW-1:0] bg_cnt [dsc_pkg::NBG];
	logic [dsc_pkg::TW-1:0] wtrs_cnt, mrd_cnt, mod_cnt, mpr_cnt;
	logic [dsc_pkg::TW-1:0] bank_val, bg_val, wtrs_val, mpr_val;
	logic [dsc_pkg::TW-1:0] wl, wr_end, ext;
	logic [3:0] bank_idx;

	assign bank_idx = {bg_q, ba_q};
	assign wl = dsc_pkg::TW'(cas_wr_lat) + dsc_pkg::TW'(add_lat) + dsc_pkg::TW'(par_lat);
	assign wr_end = wl + dsc_pkg::TW'(dsc_pkg::BURST_LEN / 2);
	assign ext = crc_dm_en ? dsc_pkg::TW'(dsc_pkg::CRC_CK) : '0;

	always_comb begin
		bank_val = '0;
		bg_val = '0;
		wtrs_val = '0;
		mpr_val = '0;
		unique case (cmd_q)
			dsc_pkg::CMD_WR: begin
				bg_val = wr_end + dsc_pkg::TW'(dsc_pkg::WTR_L_CK) + ext - 1'b1;
				wtrs_val = wr_end + dsc_pkg::TW'(dsc_pkg::WTR_S_CK) + ext - 1'b1;
				if (ap_q) begin
					bank_val = wr_end + dsc_pkg::TW'(wr_prog) + ext
						+ dsc_pkg::TW'(dsc_pkg::RP_CK) - 1'b1;
				end else begin
					bank_val = wr_end + dsc_pkg::TW'(dsc_pkg::WR_CK) + ext - 1'b1;
				end
			end
			dsc_pkg::CMD_RD: begin
				bank_val = dsc_pkg::TW'(add_lat) + dsc_pkg::TW'(dsc_pkg::RTP_CK) - 1'b1;
				if (ap_q) begin
					bank_val = bank_val + dsc_pkg::TW'(dsc_pkg::RP_CK);
				end
			end
			dsc_pkg::CMD_MPR_RD: mpr_val = dsc_pkg::TW'(dsc_pkg::MPRR_NCK);
			dsc_pkg::CMD_MPR_WR: begin
				mpr_val = dsc_pkg::TW'(dsc_pkg::MOD_CK) + dsc_pkg::TW'(add_lat)
					+ dsc_pkg::TW'(par_lat) - 1'b1;
			end
			default: bank_val = '0;
		endcase
	end

	genvar gi;
	generate
		for (gi = 0; gi < dsc_pkg::NBANK; gi++) begin : g_bank
			dsc_timer u_bank (
				.clk_sys(clk_sys),
				.sys_rst(sys_rst),
				.load(fire && (bank_idx == 4'(gi))
					&& ((cmd_q == dsc_pkg::CMD_WR) || (cmd_q == dsc_pkg::CMD_RD))),
				.load_val(bank_val),
				.count(bank_cnt[gi])
			);
		end
		for (gi = 0; gi < dsc_pkg::NBG; gi++) begin : g_bg
			dsc_timer u_bg (
				.clk_sys(clk_sys),
				.sys_rst(sys_rst),
				.load(fire && (bg_q == 2'(gi)) && (cmd_q == dsc_pkg::CMD_WR)),
				.load_val(bg_val),
				.count(bg_cnt[gi])
			);
		end
	endgenerate

	dsc_timer u_wtrs (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.load(fire && (cmd_q == dsc_pkg::CMD_WR)),
		.load_val(wtrs_val),
		.count(wtrs_cnt)
	);

	dsc_timer u_mrd (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.load(fire && (cmd_q == dsc_pkg::CMD_MRS)),
		.load_val(dsc_pkg::TW'(dsc_pkg::MRD_NCK - 1)),
		.count(mrd_cnt)
	);

	dsc_timer u_mod (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.load(fire && (cmd_q == dsc_pkg::CMD_MRS)),
		.load_val(dsc_pkg::TW'(dsc_pkg::MOD_CK - 1)),
		.count(mod_cnt)
	);

	dsc_timer u_mpr (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.load(fire && ((cmd_q == dsc_pkg::CMD_MPR_RD) || (cmd_q == dsc_pkg::CMD_MPR_WR))),
		.load_val(mpr_val),
		.count(mpr_cnt)
	);

	// ---------------------------------------------------------------
	// legality of the held command
	// ---------------------------------------------------------------
	logic legal;
	always_comb begin
		legal = (mpr_cnt == '0) && (mod_cnt == '0);
		unique case (cmd_q)
			dsc_pkg::CMD_MRS: legal = (mpr_cnt == '0) && (mrd_cnt == '0);
			dsc_pkg::CMD_RD: begin
				legal = legal && (bg_cnt[bg_q] == '0) && (wtrs_cnt == '0);
			end
			dsc_pkg::CMD_ACT, dsc_pkg::CMD_PRE: begin
				legal = legal && (bank_cnt[bank_idx] == '0);
			end
			default: legal = legal;
		endcase
	end

	// ---------------------------------------------------------------
	// issue sequencer
	// ---------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		cmd_d = cmd_q;
		{bg_d, ba_d, ap_d} = {bg_q, ba_q, ap_q};
		cal_d = cal_q;
		ready_d = ready_q;
		cs_n_d = 1'b1;
		issued_d = 1'b0;
		pin_cmd_d = dsc_pkg::CMD_NOP;
		{pin_bg_d, pin_ba_d, pin_ap_d} = {pin_bg_q, pin_ba_q, pin_ap_q};
		fire = 1'b0;
		unique case (st_q)
			dsc_pkg::ST_IDLE: begin
				if (req_valid && ready_q) begin
					cmd_d = req_cmd;
					bg_d = req_bg;
					ba_d = req_ba;
					ap_d = req_ap;
					ready_d = 1'b0;
					st_d = dsc_pkg::ST_HOLD;
				end else if (!ready_q && !req_valid) begin
					ready_d = 1'b1;
				end
			end
			dsc_pkg::ST_HOLD: begin
				if (legal && cal_en) begin
					cs_n_d = 1'b0;
					cal_d = 3'(dsc_pkg::CAL_NCK - 1);
					st_d = dsc_pkg::ST_CAL;
				end else if (legal) begin
					fire = 1'b1;
				end
			end
			dsc_pkg::ST_CAL: begin
				if (cal_q != '0) begin
					cal_d = cal_q - 1'b1;
				end else begin
					fire = 1'b1;
				end
			end
			default: st_d = dsc_pkg::ST_IDLE;
		endcase
		if (fire) begin
			cs_n_d = cal_en;
			issued_d = 1'b1;
			pin_cmd_d = cmd_q;
			{pin_bg_d, pin_ba_d, pin_ap_d} = {bg_q, ba_q, ap_q};
			ready_d = 1'b1;
			st_d = dsc_pkg::ST_IDLE;
		end
	end

	// ---------------------------------------------------------------
	// read strobe window
	// ---------------------------------------------------------------
	logic [6:0] rl;
	assign rl = 7'(cas_lat) + 7'(add_lat) + 7'(par_lat);

	always_comb begin
		hist_d = {hist_q[dsc_pkg::HIST_W-2:0], fire && (cmd_q == dsc_pkg::CMD_RD)};
		win_d = 1'b0;
		for (int j = 0; j < dsc_pkg::HIST_W; j++) begin
			if ((7'(j) + 7'd1 >= rl) && (7'(j) < rl + 7'(dsc_pkg::BURST_LEN / 2))) begin
				win_d = win_d | hist_d[j];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_q <= dsc_pkg::ST_IDLE;
			cmd_q <= dsc_pkg::CMD_NOP;
			pin_cmd_q <= dsc_pkg::CMD_NOP;
			{bg_q, ba_q, ap_q, cal_q} <= '0;
			{ready_q, issued_q, pin_ap_q, win_q} <= '0;
			{pin_bg_q, pin_ba_q, hist_q} <= '0;
			cs_n_q <= 1'b1;
		end else begin
			st_q <= st_d;
			cmd_q <= cmd_d;
			pin_cmd_q <= pin_cmd_d;
			{bg_q, ba_q, ap_q, cal_q} <= {bg_d, ba_d, ap_d, cal_d};
			{ready_q, issued_q, pin_ap_q, win_q} <= {ready_d, issued_d, pin_ap_d, win_d};
			{pin_bg_q, pin_ba_q, hist_q} <= {pin_bg_d, pin_ba_d, hist_d};
			cs_n_q <= cs_n_d;
		end
	end

	assign req_ready = ready_q;
	assign dram_cs_n = cs_n_q;
	assign dram_cmd = pin_cmd_q;
	assign dram_bg = pin_bg_q;
	assign dram_ba = pin_ba_q;
	assign dram_ap = pin_ap_q;
	assign issued = issued_q;
	assign rd_strobe_win = win_q;
endmodule : dsc_ctrl
`default_nettype wire

// File: design/dsc_pkg.sv
// Purpose: constants and types for the command spacing controller
// Assumes: command clock of 125 MHz, burst length 8
// Notes: nanosecond minimums are held in picoseconds and turned into cycles here
`default_nettype none
package dsc_pkg;
	// ---------------------------------------------------------------
	// clock and conversion
	// ---------------------------------------------------------------
	localparam int CK_PS = 8000;

	function automatic int dsc_ceil_ck(input int ps);
		return (ps + CK_PS - 1) / CK_PS;
	endfunction : dsc_ceil_ck

	function automatic int dsc_max(input int a, input int b);
		return (a > b) ? a : b;
	endfunction : dsc_max

	// ---------------------------------------------------------------
	// timing minimums
	// ---------------------------------------------------------------
	localparam int T_WTR_L_PS = 7500;
	localparam int WTR_L_NCK = 4;
	localparam int T_WTR_S_PS = 2500;
	localparam int WTR_S_NCK = 2;
	localparam int T_RTP_PS = 7500;
	localparam int RTP_NCK = 4;
	localparam int T_WR_PS = 15000;
	localparam int T_CRC_PS = 3750;
	localparam int CRC_NCK = 5;
	localparam int MRD_NCK = 8;
	localparam int T_MOD_PS = 15000;
	localparam int MOD_NCK = 24;
	localparam int MPRR_NCK = 1;
	localparam int CAL_NCK = 4;
	localparam int BURST_LEN = 8;
	// precharge time, plain default
	localparam int T_RP_PS = 15000;

	// derived cycle counts
	localparam int WTR_L_CK = dsc_max(WTR_L_NCK, dsc_ceil_ck(T_WTR_L_PS));
	localparam int WTR_S_CK = dsc_max(WTR_S_NCK, dsc_ceil_ck(T_WTR_S_PS));
	localparam int RTP_CK = dsc_max(RTP_NCK, dsc_ceil_ck(T_RTP_PS));
	localparam int WR_CK = dsc_max(1, dsc_ceil_ck(T_WR_PS));
	localparam int CRC_CK = dsc_max(CRC_NCK, dsc_ceil_ck(T_CRC_PS));
	localparam int MOD_CK = dsc_max(MOD_NCK, dsc_ceil_ck(T_MOD_PS));
	localparam int RP_CK = dsc_max(1, dsc_ceil_ck(T_RP_PS));

	// ---------------------------------------------------------------
	// widths and types
	// ---------------------------------------------------------------
	localparam int TW = 8;
	localparam int NBG = 4;
	localparam int NBANK = 16;
	localparam int HIST_W = 64;

	typedef enum logic [2:0] {
		CMD_ACT,
		CMD_RD,
		CMD_WR,
		CMD_PRE,
		CMD_MRS,
		CMD_MPR_RD,
		CMD_MPR_WR,
		CMD_NOP
	} dsc_cmd_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_HOLD,
		ST_CAL
	} dsc_state_t;
endpackage : dsc_pkg
`default_nettype wire

// File: design/dsc_timer.sv
// Purpose: spacing down-counter; a load never shortens a running wait
// Assumes: load value is the remaining cycles minus one
// Notes: count reads zero when the guarded command may issue
`timescale 1ns/100ps
`default_nettype none
module dsc_timer (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic load,
	input wire logic [dsc_pkg::TW-1:0] load_val,
	output logic [dsc_pkg::TW-1:0] count
);
	logic [dsc_pkg::TW-1:0] cnt_q;
	logic [dsc_pkg::TW-1:0] cnt_d;

	always_comb begin
		if (cnt_q != '0) begin
			cnt_d = cnt_q - 1'b1;
		end else begin
			cnt_d = '0;
		end
		if (load && (load_val > cnt_d)) begin
			cnt_d = load_val;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign count = cnt_q;
endmodule : dsc_timer
`default_nettype wire

// File: tb/dsc_ctrl_asserts.sv
// Purpose: spacing checks at the command issuer ports
// Assumes: one clock domain
// Notes: ago counters read k in the k-th cycle after an issue
`timescale 1ns/100ps
`default_nettype none
module dsc_ctrl_asserts (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic req_valid,
	input wire dsc_pkg::dsc_cmd_t req_cmd,
	input wire logic [1:0] req_bg,
	input wire logic [1:0] req_ba,
	input wire logic req_ap,
	input wire logic crc_dm_en,
	input wire logic cal_en,
	input wire logic [5:0] cas_lat,
	input wire logic [5:0] cas_wr_lat,
	input wire logic [5:0] add_lat,
	input wire logic [5:0] par_lat,
	input wire logic [5:0] wr_prog,
	input wire logic req_ready,
	input wire logic dram_cs_n,
	input wire dsc_pkg::dsc_cmd_t dram_cmd,
	input wire logic [1:0] dram_bg,
	input wire logic [1:0] dram_ba,
	input wire logic dram_ap,
	input wire logic issued,
	input wire logic rd_strobe_win
);
	logic [7:0] rd_ago_q, rd_ago_d, mrs_ago_q, mrs_ago_d, rl;
	assign rl = 8'(cas_lat) + 8'(add_lat) + 8'(par_lat);
	always_comb begin
		rd_ago_d = (rd_ago_q == 8'hFF) ? rd_ago_q : rd_ago_q + 8'h01;
		mrs_ago_d = (mrs_ago_q == 8'hFF) ? mrs_ago_q : mrs_ago_q + 8'h01;
		if (issued && dram_cmd == dsc_pkg::CMD_RD) begin
			rd_ago_d = 8'h01;
		end
		if (issued && dram_cmd == dsc_pkg::CMD_MRS) begin
			mrs_ago_d = 8'h01;
		end
		if (sys_rst) begin
			rd_ago_d = 8'hFF;
			mrs_ago_d = 8'hFF;
		end
	end
	always_ff @(posedge clk_sys) begin
		rd_ago_q <= rd_ago_d;
		mrs_ago_q <= mrs_ago_d;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	sequence cs_lead_s;
		cal_en && !dram_cs_n && !issued;
	endsequence
	sequence cal_cmd_s;
		issued && dram_cs_n;
	endsequence
	strobe_open_a: assert property ($rose(rd_strobe_win) |-> rd_ago_q == rl - 8'h01)
		else $error("strobe window opened at wrong cycle");
	strobe_close_a: assert property ($fell(rd_strobe_win) |-> rd_ago_q == rl + 8'h04)
		else $error("strobe window closed at wrong cycle");
	cal_latency_a: assert property (cs_lead_s |-> ##4 cal_cmd_s)
		else $error("command not four cycles after select");
	cs_issue_a: assert property ((!cal_en && issued) |-> !dram_cs_n)
		else $error("select missing on issue");
	mrs_gap_a: assert property (
		(issued && dram_cmd == dsc_pkg::CMD_MRS) |=> !(issued && dram_cmd == dsc_pkg::CMD_MRS) [*7])
		else $error("mode sets too close");
	mod_wait_a: assert property ((issued && dram_cmd != dsc_pkg::CMD_MRS
		&& dram_cmd != dsc_pkg::CMD_NOP) |-> mrs_ago_q >= 8'h18)
		else $error("command too soon after mode set");
	rtp_gap_a: assert property ((issued && dram_cmd == dsc_pkg::CMD_RD) |=>
		!(issued && dram_cmd == dsc_pkg::CMD_PRE && $stable(dram_bg) && $stable(dram_ba)) [*3])
		else $error("precharge too soon after read");
	wtr_gap_a: assert property ((issued && dram_cmd == dsc_pkg::CMD_WR) |=>
		!(issued && dram_cmd == dsc_pkg::CMD_RD && $stable(dram_bg)) [*7])
		else $error("read too soon after write");
	mpr_rec_a: assert property ((issued && dram_cmd == dsc_pkg::CMD_MPR_RD) |=> !issued)
		else $error("no recovery after register read");
endmodule : dsc_ctrl_asserts
`default_nettype wire

// File: tb/dsc_mem_model.sv
// Purpose: memory side model driving the read strobe window
// Assumes: burst of eight, one read tracked at a time
// Notes: strobe_oe low means the strobe is released
`timescale 1ns/100ps
`default_nettype none
module dsc_mem_model (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic issued,
	input wire dsc_pkg::dsc_cmd_t dram_cmd,
	input wire logic [7:0] rl,
	output logic strobe_oe
);
	logic [7:0] ago_q;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ago_q <= 8'hFF;
		end else if (issued && dram_cmd == dsc_pkg::CMD_RD) begin
			ago_q <= 8'h01;
		end else if (ago_q != 8'hFF) begin
			ago_q <= ago_q + 8'h01;
		end
	end
	assign strobe_oe = (ago_q >= rl - 8'h01) && (ago_q <= rl + 8'h03);
endmodule : dsc_mem_model
`default_nettype wire

// File: tb/ddr4_command_spacing_checker_tb_top.sv
// Purpose: scenario bench for the command issuer
// Assumes: CL 11, CWL 9, AL 0, PL 0, WR 10
// Notes: gaps are measured between issue cycles
`timescale 1ns/100ps
`default_nettype none
module ddr4_command_spacing_checker_tb_top;
	logic clk_sys, sys_rst, req_valid, req_ap, crc_dm_en, cal_en;
	logic req_ready, dram_cs_n, dram_ap, issued, rd_strobe_win, strobe_oe;
	dsc_pkg::dsc_cmd_t req_cmd, dram_cmd;
	logic [1:0] req_bg, req_ba, dram_bg, dram_ba;
	logic [5:0] cas_lat, cas_wr_lat, add_lat, par_lat, wr_prog;
	int fails, comparisons, cyc, t_take;
	int iss[$];
	logic [7:0] iss_fld[$];
	dsc_ctrl u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .req_valid(req_valid),
		.req_cmd(req_cmd), .req_bg(req_bg), .req_ba(req_ba), .req_ap(req_ap),
		.crc_dm_en(crc_dm_en), .cal_en(cal_en), .cas_lat(cas_lat), .cas_wr_lat(cas_wr_lat),
		.add_lat(add_lat), .par_lat(par_lat), .wr_prog(wr_prog), .req_ready(req_ready),
		.dram_cs_n(dram_cs_n), .dram_cmd(dram_cmd), .dram_bg(dram_bg), .dram_ba(dram_ba),
		.dram_ap(dram_ap), .issued(issued), .rd_strobe_win(rd_strobe_win));
	dsc_mem_model u_mem (.clk_sys(clk_sys), .sys_rst(sys_rst), .issued(issued),
		.dram_cmd(dram_cmd), .rl(8'(cas_lat) + 8'(add_lat) + 8'(par_lat)), .strobe_oe(strobe_oe));
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (issued === 1'b1) begin
			iss.push_back(cyc);
			iss_fld.push_back({dram_cmd, dram_bg, dram_ba, dram_ap});
		end
	end
	task automatic give_verdict();
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : give_verdict
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: gap %0d want %0d", $time, got, exp);
		end
	endtask : check
	task automatic send(input dsc_pkg::dsc_cmd_t c, input logic [3:0] p, input logic ap);
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 300) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		if (req_ready !== 1'b1) begin
			fails++;
			$display("unexpected at %0t: request never accepted", $time);
		end
		req_valid = 1'b1;
		req_cmd = c;
		{req_bg, req_ba} = p;
		req_ap = ap;
		@(posedge clk_sys);
		t_take = cyc;
		#1;
		req_valid = 1'b0;
	endtask : send
	task automatic wait_iss(input int k);
		int n;
		n = 0;
		while (iss.size() < k && n < 300) begin
			@(posedge clk_sys);
			n++;
		end
		if (iss.size() < k) begin
			fails++;
			$display("unexpected at %0t: command never issued", $time);
		end
		repeat (40) @(posedge clk_sys);
		#1;
	endtask : wait_iss
	task automatic pair(input dsc_pkg::dsc_cmd_t a, input logic [3:0] pa, input logic apa,
		input dsc_pkg::dsc_cmd_t b, input logic [3:0] pb, input int exp);
		iss.delete();
		iss_fld.delete();
		send(a, pa, apa);
		send(b, pb, 1'b0);
		wait_iss(2);
		check(iss[1] - iss[0], exp);
		check(iss_fld[0], {a, pa, apa});
		check(iss_fld[1], {b, pb, 1'b0});
	endtask : pair
	task automatic t_wtr();
		pair(dsc_pkg::CMD_WR, 4'h0, 1'b0, dsc_pkg::CMD_RD, 4'h1, 9 + 4 + 4);
		pair(dsc_pkg::CMD_WR, 4'h0, 1'b0, dsc_pkg::CMD_RD, 4'h4, 9 + 4 + 2);
	endtask : t_wtr
	task automatic t_crc();
		crc_dm_en = 1'b1;
		pair(dsc_pkg::CMD_WR, 4'h5, 1'b0, dsc_pkg::CMD_RD, 4'h6, 9 + 4 + 4 + 5);
		pair(dsc_pkg::CMD_WR, 4'h5, 1'b0, dsc_pkg::CMD_RD, 4'h9, 9 + 4 + 2 + 5);
		pair(dsc_pkg::CMD_WR, 4'h5, 1'b0, dsc_pkg::CMD_PRE, 4'h5, 9 + 4 + 2 + 5);
		crc_dm_en = 1'b0;
	endtask : t_crc
	task automatic t_wr();
		pair(dsc_pkg::CMD_WR, 4'hB, 1'b0, dsc_pkg::CMD_PRE, 4'hB, 9 + 4 + 2);
		pair(dsc_pkg::CMD_WR, 4'hB, 1'b1, dsc_pkg::CMD_ACT, 4'hB, 9 + 4 + 10 + 2);
	endtask : t_wr
	task automatic t_misc();
		pair(dsc_pkg::CMD_RD, 4'h7, 1'b0, dsc_pkg::CMD_PRE, 4'h7, 4);
		pair(dsc_pkg::CMD_RD, 4'h7, 1'b1, dsc_pkg::CMD_ACT, 4'h7, 4 + 2);
		pair(dsc_pkg::CMD_MRS, 4'h0, 1'b0, dsc_pkg::CMD_MRS, 4'h1, 8);
		pair(dsc_pkg::CMD_MRS, 4'h0, 1'b0, dsc_pkg::CMD_ACT, 4'h2, 24);
		pair(dsc_pkg::CMD_MPR_RD, 4'h0, 1'b0, dsc_pkg::CMD_RD, 4'h3, 2);
		pair(dsc_pkg::CMD_MPR_WR, 4'h0, 1'b0, dsc_pkg::CMD_RD, 4'h3, 24 + 0 + 0);
		add_lat = 6'h02;
		par_lat = 6'h01;
		pair(dsc_pkg::CMD_MPR_WR, 4'h0, 1'b0, dsc_pkg::CMD_RD, 4'h3, 24 + 2 + 1);
		add_lat = 6'h00;
		par_lat = 6'h00;
	endtask : t_misc
	task automatic t_cal();
		int lat;
		iss.delete();
		send(dsc_pkg::CMD_ACT, 4'hC, 1'b0);
		wait_iss(1);
		lat = iss[0] - t_take;
		cal_en = 1'b1;
		iss.delete();
		send(dsc_pkg::CMD_ACT, 4'hD, 1'b0);
		wait_iss(1);
		check(iss[0] - t_take - lat, 4);
		cal_en = 1'b0;
	endtask : t_cal
	task automatic t_reset();
		iss.delete();
		send(dsc_pkg::CMD_MRS, 4'h0, 1'b0);
		sys_rst = 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		sys_rst = 1'b0;
		check(iss.size(), 0);
		check({req_ready, dram_cs_n, issued, rd_strobe_win}, 4'h4);
		@(posedge clk_sys);
		#1;
		check(req_ready, 1'b1);
	endtask : t_reset
	task automatic t_strobe();
		send(dsc_pkg::CMD_RD, 4'h6, 1'b0);
		repeat (24) begin
			@(posedge clk_sys);
			#1;
			comparisons++;
			if (rd_strobe_win !== strobe_oe) begin
				fails++;
				$display("unexpected at %0t: strobe window", $time);
			end
		end
	endtask : t_strobe
	initial begin
		sys_rst = 1'b1;
		req_valid = 1'b0;
		req_cmd = dsc_pkg::CMD_NOP;
		{req_bg, req_ba, req_ap} = 5'h00;
		crc_dm_en = 1'b0;
		cal_en = 1'b0;
		cas_lat = 6'h0B;
		cas_wr_lat = 6'h09;
		add_lat = 6'h00;
		par_lat = 6'h00;
		wr_prog = 6'h0A;
		fails = 0;
		comparisons = 0;
		cyc = 0;
		repeat (2) @(posedge clk_sys);
		#1;
		sys_rst = 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		t_wtr();
		t_crc();
		t_wr();
		t_misc();
		t_cal();
		t_reset();
		t_strobe();
		give_verdict();
	end
	initial begin
		#200000;
		fails++;
		give_verdict();
	end
endmodule : ddr4_command_spacing_checker_tb_top
bind dsc_ctrl dsc_ctrl_asserts u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.req_valid(req_valid), .req_cmd(req_cmd), .req_bg(req_bg), .req_ba(req_ba),
	.req_ap(req_ap), .crc_dm_en(crc_dm_en), .cal_en(cal_en), .cas_lat(cas_lat),
	.cas_wr_lat(cas_wr_lat), .add_lat(add_lat), .par_lat(par_lat), .wr_prog(wr_prog),
	.req_ready(req_ready), .dram_cs_n(dram_cs_n), .dram_cmd(dram_cmd), .dram_bg(dram_bg),
	.dram_ba(dram_ba), .dram_ap(dram_ap), .issued(issued), .rd_strobe_win(rd_strobe_win));
`default_nettype wire
